// ---- logic/sts_pkg.sv ----
package sts_pkg;

  // Data path widths.
  localparam int SAMPLE_W = 16;
  localparam int ADDR_W = 16;
  localparam int LEN_W = ADDR_W + 1;
  localparam int SEG_W = 16;
  localparam int PCT_W = 16;
  localparam int REF_W = 8;
  localparam int HEV_W = 20;
  localparam int HT_W = 32;
  localparam int TC_W = 32;

  // Memory size in samples and the segment limits.
  localparam int MEM_DEPTH = 65536;
  localparam logic [SEG_W-1:0] SEG_MIN = 16'h0001;
  localparam logic [SEG_W-1:0] SEG_MAX = 16'h8000;

  // Event holdoff limits.
  localparam logic [HEV_W-1:0] HOLDOFF_EV_MIN = 20'h00001;
  localparam logic [HEV_W-1:0] HOLDOFF_EV_MAX = 20'hfffff;

  // Percentage scale and the reference position after reset.
  localparam logic [31:0] PCT_FULL = 32'h00000064;
  localparam logic [REF_W-1:0] REF_DEFAULT = 8'h32;
  localparam logic [REF_W-1:0] REF_MAX = 8'h64;

  // Buffer between the sample stream and the memory port.
  localparam int FIFO_DEPTH = 4;

  // Edge selection.
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} sts_edge_t;

  // Gating source selection.
  typedef enum logic [1:0] {GATE_IN3_HIGH, GATE_IN3_LOW, GATE_IN4_HIGH, GATE_IN4_LOW} sts_gate_t;

  // Holdoff measure.
  typedef enum logic {HOLD_TIME, HOLD_EVENTS} sts_hold_t;

  // Capture sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_CALC1, ST_CALC2, ST_FILL, ST_WAIT, ST_POST} sts_state_t;

endpackage

// ---- logic/sts_fifo.sv ----
`timescale 1ns/1ps
module sts_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  // Refuse depths that the pointer arithmetic cannot serve.
  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("sts_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtrQ;
  logic [PW:0] rdPtrQ;
  logic push;
  logic pop;

  // Pointers carry one extra bit so full and empty differ.
  assign inReady = (wrPtrQ[PW] == rdPtrQ[PW]) || (wrPtrQ[PW-1:0] != rdPtrQ[PW-1:0]);
  assign outValid = wrPtrQ != rdPtrQ;
  assign outData = mem[rdPtrQ[PW-1:0]];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Pointer update.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
    end else begin
      if (push) wrPtrQ <= wrPtrQ + 1'b1;
      if (pop) rdPtrQ <= rdPtrQ + 1'b1;
    end
  end

  // Storage is written only on an accepted word.
  always_ff @(posedge clk_sys) begin
    if (push) mem[wrPtrQ[PW-1:0]] <= inData;
  end

endmodule // sts_fifo

// ---- logic/sts_trigger_segmenter.sv ----
// How it works
// - After firing, rearm only once the source left the level by the hysteresis.
// - Zero hysteresis rearms with no excursion beyond the level.
// - Rearm direction follows edge; hysteresis magnitude is unsigned, hence positive.
// - Relative hysteresis is percent of full scale; above one hundred allowed.
// - Gate source: input 3 high, 3 low, 4 high or 4 low.
// - Gating enable qualifies trigger events; clear means gating ignored.
// - Holdoff mode chooses time or event count.
// - Time holdoff keeps recording disarmed for the holdoff time after a recording.
// - Event holdoff 1 to 1048575; Nth event records, one records every event.
// - Reference position is a percent of the window, default fifty.
// - Positive delay shortens pre-trigger data, negative delay lengthens it.
// - Segmented mode captures successive shots back to back into memory.
// - Segments 1 to 32768; shot length limited to memory over segments.
// - Trigger events since last start are counted and readable.
// - Trigger disabled means shots are captured continuously.
// - Edge choice: none, rising, falling, or either.
`timescale 1ns/1ps
module sts_trigger_segmenter #(
  parameter int MEM_DEPTH = sts_pkg::MEM_DEPTH,
  parameter int FIFO_DEPTH = sts_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Sample stream.
  input wire logic sampleValid,
  input wire logic signed [sts_pkg::SAMPLE_W-1:0] sampleData,
  // Auxiliary trigger inputs.
  input wire logic trigIn3,
  input wire logic trigIn4,
  // Acquisition control.
  input wire logic acqStart,
  input wire logic acqStop,
  // Trigger settings.
  input wire logic trigEnable,
  input wire sts_pkg::sts_edge_t edgeSel,
  input wire logic signed [sts_pkg::SAMPLE_W-1:0] trigLevel,
  input wire logic hystRelative,
  input wire logic [sts_pkg::SAMPLE_W-1:0] hystAbs,
  input wire logic [sts_pkg::PCT_W-1:0] hystPct,
  input wire logic [sts_pkg::SAMPLE_W-1:0] fullScale,
  input wire logic gateEnable,
  input wire sts_pkg::sts_gate_t gateSel,
  input wire sts_pkg::sts_hold_t holdoffMode,
  input wire logic [sts_pkg::HT_W-1:0] holdoffCycles,
  input wire logic [sts_pkg::HEV_W-1:0] holdoffEvents,
  // Window settings.
  input wire logic [sts_pkg::REF_W-1:0] refPct,
  input wire logic signed [sts_pkg::LEN_W-1:0] trigDelay,
  input wire logic [sts_pkg::LEN_W-1:0] shotLength,
  input wire logic segEnable,
  input wire logic [sts_pkg::SEG_W-1:0] segCount,
  // Memory write port.
  output logic memWrEn,
  output logic [sts_pkg::ADDR_W-1:0] memAddr,
  output logic [sts_pkg::SAMPLE_W-1:0] memData,
  input wire logic memReady,
  // Status.
  output logic acqBusy,
  output logic acqDone,
  output logic trigEventPulse,
  output logic [sts_pkg::TC_W-1:0] trigCount,
  output logic [sts_pkg::SEG_W-1:0] segIndex,
  output logic shotDone,
  output logic [sts_pkg::ADDR_W-1:0] shotStartAddr,
  output logic dataLost
);

  localparam int W = sts_pkg::SAMPLE_W;
  localparam int AW = sts_pkg::ADDR_W;
  localparam int LW = sts_pkg::LEN_W;
  localparam int FW = AW + W;
  localparam logic [LW-1:0] MEM_LEN = LW'(MEM_DEPTH);
  localparam logic [LW-1:0] LEN_ONE = 17'h00001;
  localparam logic [W-1:0] HYST_MAX = 16'hffff;

  // Memory must cover at least one sample per segment and fit the address.
  if (MEM_DEPTH < 32768 || MEM_DEPTH > (1 << AW) || FIFO_DEPTH < 2) begin : g_bad
    $error("sts_trigger_segmenter: MEM_DEPTH or FIFO_DEPTH out of range");
  end

  sts_pkg::sts_state_t stateQ;
  logic [AW-1:0] segBaseQ;
  logic [sts_pkg::SEG_W-1:0] segIdxQ;
  logic [sts_pkg::SEG_W-1:0] segTotalQ;
  logic [LW-1:0] segLenQ;
  logic [LW-1:0] lenQ;
  logic [LW-1:0] preQ;
  logic [LW-1:0] wOffQ;
  logic [LW-1:0] fillCntQ;
  logic [LW-1:0] postLeftQ;
  logic armLoQ;
  logic armHiQ;
  logic [sts_pkg::HT_W-1:0] holdTimerQ;
  logic [sts_pkg::HEV_W-1:0] evCntQ;
  logic firstQ;
  logic [W-1:0] hystQ;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [FW-1:0] fifoOutData;

  // Sample handling: a sample is dropped only while writing and the buffer is full.
  logic writing;
  logic take;
  logic evalStep;
  assign writing = stateQ == sts_pkg::ST_FILL || stateQ == sts_pkg::ST_WAIT || stateQ == sts_pkg::ST_POST;
  assign take = sampleValid && writing && fifoInReady;
  assign evalStep = sampleValid && (fifoInReady || !writing);

  // Hysteresis magnitude, absolute or as a clamped percentage of full scale.
  logic [31:0] hystProd;
  logic [31:0] hystRel;
  logic [W-1:0] hystD;
  assign hystProd = 32'(fullScale) * 32'(hystPct);
  assign hystRel = hystProd / sts_pkg::PCT_FULL;
  assign hystD = hystRelative ? ((hystRel > 32'(HYST_MAX)) ? HYST_MAX : hystRel[W-1:0]) : hystAbs;

  // Thresholds widened by two bits so level plus hysteresis cannot wrap.
  logic signed [W+1:0] sampleX;
  logic signed [W+1:0] levelX;
  logic signed [W+1:0] lowThr;
  logic signed [W+1:0] highThr;
  assign sampleX = {{2{sampleData[W-1]}}, sampleData};
  assign levelX = {{2{trigLevel[W-1]}}, trigLevel};
  assign lowThr = levelX - $signed({2'b00, hystQ});
  assign highThr = levelX + $signed({2'b00, hystQ});

  // Level crossing from an armed side.
  logic fireRise;
  logic fireFall;
  logic fire;
  logic gateOk;
  logic trigEvent;
  assign fireRise = armLoQ && sampleX >= levelX && (edgeSel == sts_pkg::EDGE_RISE || edgeSel == sts_pkg::EDGE_BOTH);
  assign fireFall = armHiQ && sampleX <= levelX && (edgeSel == sts_pkg::EDGE_FALL || edgeSel == sts_pkg::EDGE_BOTH);
  assign fire = fireRise || fireFall;

  // Gate condition from the chosen auxiliary input.
  always_comb begin
    case (gateSel)
      sts_pkg::GATE_IN3_HIGH: gateOk = trigIn3;
      sts_pkg::GATE_IN3_LOW: gateOk = !trigIn3;
      sts_pkg::GATE_IN4_HIGH: gateOk = trigIn4;
      default: gateOk = !trigIn4;
    endcase
    if (!gateEnable) gateOk = 1'b1;
  end

  assign trigEvent = evalStep && acqBusy && trigEnable && fire && gateOk;

  // Holdoff readiness and the recording decision.
  logic [sts_pkg::HEV_W-1:0] evNeed;
  logic holdReady;
  logic recordTrig;
  assign evNeed = (holdoffEvents < sts_pkg::HOLDOFF_EV_MIN) ? sts_pkg::HOLDOFF_EV_MIN : holdoffEvents;
  always_comb begin
    if (holdoffMode == sts_pkg::HOLD_TIME) begin
      holdReady = holdTimerQ == '0;
    end else begin
      holdReady = firstQ || (evCntQ + 1'b1) >= evNeed;
    end
  end
  assign recordTrig = stateQ == sts_pkg::ST_WAIT && take && (trigEnable ? trigEvent && holdReady : 1'b1);

  // Setup arithmetic: segment size, shot length and pre-trigger count.
  logic [sts_pkg::SEG_W-1:0] segTotalD;
  logic [LW-1:0] segLenD;
  logic [LW-1:0] shotD;
  logic [LW-1:0] lenD;
  localparam int REF_W_HELPER = sts_pkg::REF_W;
  logic [REF_W_HELPER-1:0] refD;
  logic [LW+REF_W_HELPER-1:0] preProd;
  logic signed [LW+REF_W_HELPER+1:0] preS;
  logic [LW-1:0] preD;
  always_comb begin
    segTotalD = sts_pkg::SEG_MIN;
    if (segEnable) begin
      segTotalD = (segCount < sts_pkg::SEG_MIN) ? sts_pkg::SEG_MIN : segCount;
      if (segTotalD > sts_pkg::SEG_MAX) segTotalD = sts_pkg::SEG_MAX;
    end
  end
  assign segLenD = MEM_LEN / LW'(segTotalQ);
  assign shotD = (shotLength < LEN_ONE) ? LEN_ONE : shotLength;
  assign lenD = (shotD > segLenQ) ? segLenQ : shotD;
  assign refD = (refPct > sts_pkg::REF_MAX) ? sts_pkg::REF_MAX : refPct;
  assign preProd = (LW + REF_W_HELPER)'((LW + REF_W_HELPER)'(lenD) * (LW + REF_W_HELPER)'(refD)
                   / (LW + REF_W_HELPER)'(sts_pkg::PCT_FULL));
  assign preS = $signed({2'b00, preProd}) - (LW + REF_W_HELPER + 2)'(trigDelay);
  always_comb begin
    if (preS < 0) begin
      preD = '0;
    end else if (preS > $signed((LW + REF_W_HELPER + 2)'(lenD - LEN_ONE))) begin
      preD = lenD - LEN_ONE;
    end else begin
      preD = preS[LW-1:0];
    end
  end

  // Ring offset of the next sample inside the current segment.
  logic [LW-1:0] wOffNext;
  logic [LW-1:0] startOff;
  logic lastSeg;
  assign wOffNext = (wOffQ + LEN_ONE >= lenQ) ? '0 : wOffQ + LEN_ONE;
  assign startOff = (wOffQ >= preQ) ? wOffQ - preQ : wOffQ + lenQ - preQ;
  assign lastSeg = segIdxQ + 1'b1 >= segTotalQ;

  // Capture sequencing: setup, pre-trigger fill, trigger wait, post-trigger, segments.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stateQ <= sts_pkg::ST_IDLE;
      segBaseQ <= '0;
      segIdxQ <= '0;
      segTotalQ <= sts_pkg::SEG_MIN;
      segLenQ <= '0;
      lenQ <= LEN_ONE;
      preQ <= '0;
      wOffQ <= '0;
      fillCntQ <= '0;
      postLeftQ <= '0;
      shotStartAddr <= '0;
    end else if (acqStop) begin
      stateQ <= sts_pkg::ST_IDLE;
    end else begin
      case (stateQ)
        sts_pkg::ST_IDLE: begin
          if (acqStart) begin
            segTotalQ <= segTotalD;
            stateQ <= sts_pkg::ST_CALC1;
          end
        end
        sts_pkg::ST_CALC1: begin
          segLenQ <= segLenD;
          stateQ <= sts_pkg::ST_CALC2;
        end
        sts_pkg::ST_CALC2: begin
          lenQ <= lenD;
          preQ <= preD;
          segBaseQ <= '0;
          segIdxQ <= '0;
          wOffQ <= '0;
          fillCntQ <= '0;
          stateQ <= (preD == '0) ? sts_pkg::ST_WAIT : sts_pkg::ST_FILL;
        end
        sts_pkg::ST_FILL: begin
          if (take) begin
            wOffQ <= wOffNext;
            fillCntQ <= fillCntQ + LEN_ONE;
            if (fillCntQ + LEN_ONE >= preQ) stateQ <= sts_pkg::ST_WAIT;
          end
        end
        sts_pkg::ST_WAIT: begin
          if (take) wOffQ <= wOffNext;
          if (recordTrig) begin
            shotStartAddr <= segBaseQ + startOff[AW-1:0];
            postLeftQ <= lenQ - preQ - LEN_ONE;
            stateQ <= sts_pkg::ST_POST;
            if (lenQ - preQ == LEN_ONE) begin
              stateQ <= lastSeg ? sts_pkg::ST_IDLE : ((preQ == '0) ? sts_pkg::ST_WAIT : sts_pkg::ST_FILL);
              segBaseQ <= segBaseQ + segLenQ[AW-1:0];
              segIdxQ <= segIdxQ + 1'b1;
              wOffQ <= '0;
              fillCntQ <= '0;
            end
          end
        end
        sts_pkg::ST_POST: begin
          if (take) begin
            wOffQ <= wOffNext;
            postLeftQ <= postLeftQ - LEN_ONE;
            if (postLeftQ == LEN_ONE) begin
              // Next segment starts at once for minimal dead time.
              stateQ <= lastSeg ? sts_pkg::ST_IDLE : ((preQ == '0) ? sts_pkg::ST_WAIT : sts_pkg::ST_FILL);
              segBaseQ <= segBaseQ + segLenQ[AW-1:0];
              segIdxQ <= segIdxQ + 1'b1;
              wOffQ <= '0;
              fillCntQ <= '0;
            end
          end
        end
        default: stateQ <= sts_pkg::ST_IDLE;
      endcase
    end
  end

  // Arming on both sides of the level; firing disarms until the excursion repeats.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armLoQ <= 1'b0;
      armHiQ <= 1'b0;
      hystQ <= '0;
    end else begin
      hystQ <= hystD;
      if (acqStart && stateQ == sts_pkg::ST_IDLE) begin
        armLoQ <= 1'b0;
        armHiQ <= 1'b0;
      end else if (evalStep) begin
        if (fire) begin
          armLoQ <= 1'b0;
          armHiQ <= 1'b0;
        end else begin
          // With zero hysteresis the thresholds equal the level itself.
          if (sampleX <= lowThr) armLoQ <= 1'b1;
          if (sampleX >= highThr) armHiQ <= 1'b1;
        end
      end
    end
  end

  // Holdoff timer and event counter, both restarted by each recording.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      holdTimerQ <= '0;
      evCntQ <= '0;
      firstQ <= 1'b1;
    end else if (acqStart && stateQ == sts_pkg::ST_IDLE) begin
      holdTimerQ <= '0;
      evCntQ <= '0;
      firstQ <= 1'b1;
    end else if (recordTrig) begin
      holdTimerQ <= holdoffCycles;
      evCntQ <= '0;
      firstQ <= 1'b0;
    end else begin
      if (holdTimerQ != '0) holdTimerQ <= holdTimerQ - 1'b1;
      if (trigEvent && evCntQ != sts_pkg::HOLDOFF_EV_MAX) evCntQ <= evCntQ + 1'b1;
    end
  end

  // Status: event count, busy, done, loss; a loss in the start cycle still sets the flag.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trigCount <= '0;
      trigEventPulse <= 1'b0;
      acqBusy <= 1'b0;
      acqDone <= 1'b0;
      shotDone <= 1'b0;
      segIndex <= '0;
      dataLost <= 1'b0;
    end else begin
      trigEventPulse <= trigEvent;
      if (acqStart && stateQ == sts_pkg::ST_IDLE && !acqStop) begin
        trigCount <= '0;
        acqBusy <= 1'b1;
        acqDone <= 1'b0;
      end else begin
        if (trigEvent) trigCount <= trigCount + 1'b1;
        if (acqStop) acqBusy <= 1'b0;
        if (acqBusy && stateQ == sts_pkg::ST_IDLE && !acqStop) begin
          acqBusy <= 1'b0;
          acqDone <= 1'b1;
        end
      end
      shotDone <= segIdxQ != segIndex && stateQ != sts_pkg::ST_CALC2;
      segIndex <= segIdxQ;
      if (sampleValid && writing && !fifoInReady) begin
        dataLost <= 1'b1;
      end else if (acqStart && stateQ == sts_pkg::ST_IDLE) begin
        dataLost <= 1'b0;
      end
    end
  end

  sts_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(take),
    .inReady(fifoInReady),
    .inData({segBaseQ + wOffQ[AW-1:0], sampleData}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // Output stage holds a word until memory accepts it.
  assign fifoOutReady = !memWrEn || memReady;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      memWrEn <= 1'b0;
      memAddr <= '0;
      memData <= '0;
    end else if (fifoOutReady) begin
      memWrEn <= fifoOutValid;
      if (fifoOutValid) begin
        memAddr <= fifoOutData[FW-1:W];
        memData <= fifoOutData[W-1:0];
      end
    end
  end

endmodule // sts_trigger_segmenter

// ---- verification/sts_trigger_segmenter_assertions.sv ----
`timescale 1ns/1ps
// Watches the trigger, capture and memory ports of the block.
module sts_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Settings.
  input wire logic acqStart,
  input wire logic trigEnable,
  input wire sts_pkg::sts_edge_t edgeSel,
  input wire logic gateEnable,
  input wire sts_pkg::sts_gate_t gateSel,
  input wire logic trigIn3,
  input wire logic trigIn4,
  input wire logic segEnable,
  input wire logic [sts_pkg::SEG_W-1:0] segCount,
  // Outputs.
  input wire logic memWrEn,
  input wire logic [sts_pkg::ADDR_W-1:0] memAddr,
  input wire logic [sts_pkg::SAMPLE_W-1:0] memData,
  input wire logic memReady,
  input wire logic acqBusy,
  input wire logic acqDone,
  input wire logic trigEventPulse,
  input wire logic [sts_pkg::TC_W-1:0] trigCount,
  input wire logic [sts_pkg::SEG_W-1:0] segIndex,
  input wire logic dataLost
);
  logic gateFalse;

  // High while gating is on and the chosen auxiliary input blocks triggers.
  assign gateFalse = gateEnable && ((gateSel[1] ? trigIn4 : trigIn3) == gateSel[0]);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_count_on_event: assert property (trigEventPulse |-> trigCount == $past(trigCount) + 1)
    else $error("trigger count did not step with the event pulse");
  a_count_only_events: assert property ($changed(trigCount) |-> trigEventPulse || $past(acqStart))
    else $error("trigger count moved without an event or a start");
  a_trig_off_quiet: assert property ((!trigEnable || edgeSel == sts_pkg::EDGE_NONE) [*2] |=> !trigEventPulse)
    else $error("event pulse while triggering is off");
  a_gate_blocks_event: assert property (gateFalse [*2] |=> !trigEventPulse)
    else $error("event pulse while the gate was closed");
  a_idle_no_event: assert property (!acqBusy [*3] |=> !trigEventPulse)
    else $error("event pulse outside an acquisition");
  a_mem_write_held: assert property (memWrEn && !memReady |=> memWrEn && $stable(memAddr) && $stable(memData))
    else $error("memory write changed before it was accepted");
  a_done_not_busy: assert property (acqDone |-> !acqBusy)
    else $error("done and busy at the same time");
  a_all_segments: assert property ($rose(acqDone) |-> ##[0:2] segIndex == (segEnable ? segCount : 16'h0001))
    else $error("acquisition finished with a wrong segment count");
  a_lost_sticky: assert property (dataLost && !acqStart |=> dataLost)
    else $error("data loss flag cleared without a start");
endmodule // sts_checker

bind sts_trigger_segmenter sts_checker chk_u (.clk_sys, .resetn, .acqStart, .trigEnable, .edgeSel, .gateEnable,
  .gateSel, .trigIn3, .trigIn4, .segEnable, .segCount, .memWrEn, .memAddr, .memData, .memReady, .acqBusy,
  .acqDone, .trigEventPulse, .trigCount, .segIndex, .dataLost);

// ---- verification/tb_sts_trigger_segmenter.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("mismatch at %0t: value differs", $time); end end
module tb_sts_trigger_segmenter;
  // Design inputs.
  logic clk_sys = 1'b0, resetn = 1'b0, acqStart = 1'b0, acqStop = 1'b0, trigEnable = 1'b0, hystRelative = 1'b0;
  logic gateEnable = 1'b0, trigIn3 = 1'b0, trigIn4 = 1'b0, segEnable = 1'b0, memReady = 1'b1, sampleValid = 1'b0;
  logic signed [sts_pkg::SAMPLE_W-1:0] sampleData = '0, trigLevel = 16'sh0001;
  logic [sts_pkg::SAMPLE_W-1:0] hystAbs = '0, fullScale = '0;
  logic [sts_pkg::PCT_W-1:0] hystPct = '0;
  sts_pkg::sts_edge_t edgeSel = sts_pkg::EDGE_NONE;
  sts_pkg::sts_gate_t gateSel = sts_pkg::GATE_IN3_HIGH;
  sts_pkg::sts_hold_t holdoffMode = sts_pkg::HOLD_TIME;
  logic [sts_pkg::HT_W-1:0] holdoffCycles = 32'h00000005;
  logic [sts_pkg::HEV_W-1:0] holdoffEvents = 20'h00001;
  logic [sts_pkg::REF_W-1:0] refPct = 8'h32;
  logic signed [sts_pkg::LEN_W-1:0] trigDelay = '0;
  logic [sts_pkg::LEN_W-1:0] shotLength = 17'h003e8;
  logic [sts_pkg::SEG_W-1:0] segCount = 16'h0001;
  // Design outputs.
  logic memWrEn, acqBusy, acqDone, trigEventPulse, shotDone, dataLost;
  logic [sts_pkg::ADDR_W-1:0] memAddr, shotStartAddr;
  logic [sts_pkg::SAMPLE_W-1:0] memData;
  logic [sts_pkg::TC_W-1:0] trigCount;
  logic [sts_pkg::SEG_W-1:0] segIndex;
  // Scoreboard state.
  int fails = 0, samples_checked = 0, wrCount = 0, shotCount = 0;
  int pat[4] = '{-100, 2, 100, -20};
  bit segMode = 0;
  logic [sts_pkg::TC_W-1:0] expQ[$];
  logic [sts_pkg::ADDR_W-1:0] baseQ[$];
  logic [sts_pkg::SAMPLE_W-1:0] dataQ[$];

  sts_trigger_segmenter dut_u (.clk_sys, .resetn, .sampleValid, .sampleData, .trigIn3, .trigIn4, .acqStart,
    .acqStop, .trigEnable, .edgeSel, .trigLevel, .hystRelative, .hystAbs, .hystPct, .fullScale, .gateEnable,
    .gateSel, .holdoffMode, .holdoffCycles, .holdoffEvents, .refPct, .trigDelay, .shotLength, .segEnable,
    .segCount, .memWrEn, .memAddr, .memData, .memReady, .acqBusy, .acqDone, .trigEventPulse, .trigCount,
    .segIndex, .shotDone, .shotStartAddr, .dataLost);

  // Sample clock at 10 MHz.
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // Takes the oldest note whenever an event, or in segmented mode a memory write, appears.
  always @(posedge clk_sys) begin
    if (trigEventPulse === 1'b1) begin
      if (expQ.size() == 0) begin
        fails++;
        $display("mismatch at %0t: event not expected", $time);
      end else `CHK(trigCount, expQ.pop_front())
    end
    if (shotDone === 1'b1) shotCount++;
    if (memWrEn === 1'b1 && memReady === 1'b1) begin
      wrCount++;
      if (segMode) `CHK(memAddr - baseQ.pop_front() < 16'h0004, 1'b1)
      if (segMode) `CHK(memData, dataQ.pop_front())
    end
  end

  // Moves the inputs a fixed delay after each rising edge.
  task automatic tick(int n = 1);
    repeat (n) begin
      @(posedge clk_sys);
      #10;
    end
  endtask

  // Resets in mid-run and starts a fresh acquisition.
  task automatic restart();
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(1);
    acqStart = 1'b1;
    tick(1);
    acqStart = 1'b0;
    tick(2);
  endtask

  // Drives one trigger configuration and notes every event a level crossing model predicts.
  task automatic trig_run(int i);
    int h, n, s;
    bit armR, armF, fire, ok;
    edgeSel = (i == 4) ? sts_pkg::EDGE_NONE : (i == 5) ? sts_pkg::EDGE_BOTH :
      i[0] ? sts_pkg::EDGE_FALL : sts_pkg::EDGE_RISE;
    hystRelative = i[0] || (i == 6);
    fullScale = (i == 6) ? 16'h0064 : 16'h01f4;
    hystPct = (i == 6) ? 16'h0096 : (i == 5) ? 16'h000a : 16'(2 * $urandom_range(20));
    hystAbs = (i == 0) ? '0 : 16'(2 * $urandom_range(40));
    h = hystRelative ? int'(fullScale) * int'(hystPct) / 100 : int'(hystAbs);
    gateEnable = i[1];
    gateSel = sts_pkg::sts_gate_t'($urandom_range(3));
    trigIn3 = 1'($urandom_range(1));
    trigIn4 = 1'($urandom_range(1));
    ok = !gateEnable || ((gateSel[1] ? trigIn4 : trigIn3) != gateSel[0]);
    trigEnable = 1'b1;
    trigDelay = 17'(int'($urandom_range(200)) - 100);
    holdoffMode = sts_pkg::sts_hold_t'($urandom_range(1));
    holdoffEvents = 20'($urandom_range(9, 1));
    holdoffCycles = 32'($urandom_range(9));
    restart();
    n = 0;
    armR = 0;
    armF = 0;
    sampleValid = 1'b1;
    for (int k = 0; k < 120; k++) begin
      s = (edgeSel == sts_pkg::EDGE_BOTH) ? pat[k % 4] : 2 * int'($urandom_range(200)) - 200;
      sampleData = 16'(s);
      fire = ok && ((edgeSel[0] && armR && s > 1) || (edgeSel[1] && armF && s < 1));
      if (fire) begin
        armR = 0;
        armF = 0;
        n++;
        expQ.push_back(32'(n));
      end
      if (s <= 1 - h) armR = 1;
      if (s >= 1 + h) armF = 1;
      tick(1);
    end
    sampleValid = 1'b0;
    tick(4);
    `CHK(expQ.size(), 0)
    `CHK(trigCount, 32'(n))
  endtask

  // Continuous segmented capture with a stalling memory port.
  task automatic seg_run();
    trigEnable = 1'b0;
    segEnable = 1'b1;
    segCount = 16'h0003;
    shotLength = 17'h00004;
    trigDelay = '0;
    for (int k = 0; k < 12; k++) baseQ.push_back(16'(sts_pkg::MEM_DEPTH / 3 * (k / 4)));
    segMode = 1;
    restart();
    wrCount = 0;
    shotCount = 0;
    for (int k = 0; k < 400 && acqDone !== 1'b1; k++) begin
      sampleValid = (k % 4 == 0);
      sampleData = 16'($urandom);
      if (sampleValid) dataQ.push_back(sampleData);
      memReady = 1'($urandom_range(1));
      tick(1);
    end
    sampleValid = 1'b0;
    memReady = 1'b1;
    tick(20);
    `CHK(wrCount, 12)
    `CHK(shotCount, 3)
    `CHK(segIndex, 16'h0003)
    `CHK(acqDone, 1'b1)
    `CHK(dataLost, 1'b0)
    `CHK(dataQ.size(), 0)
    `CHK(shotStartAddr - 16'(sts_pkg::MEM_DEPTH / 3 * 2) < 16'h0004, 1'b1)
    segMode = 0;
  endtask

  // Fills the buffer against a refusing memory, then drains it and aborts.
  task automatic lost_run();
    segEnable = 1'b0;
    shotLength = 17'h003e8;
    restart();
    memReady = 1'b0;
    sampleValid = 1'b1;
    tick(12);
    `CHK(dataLost, 1'b1)
    `CHK(memWrEn, 1'b1)
    sampleValid = 1'b0;
    memReady = 1'b1;
    tick(14);
    `CHK(memWrEn, 1'b0)
    acqStop = 1'b1;
    tick(1);
    acqStop = 1'b0;
    tick(2);
    `CHK(acqBusy, 1'b0)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h0e8dba97));
    tick(5);
    `CHK({acqBusy, acqDone, memWrEn, trigEventPulse, shotDone, dataLost}, 6'h00)
    `CHK(trigCount, 32'h00000000)
    tick(1);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++) trig_run(i);
    seg_run();
    lost_run();
    final_report();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #500000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule // tb_sts_trigger_segmenter
